// ===== pkg/irq_ctrl_map.vh
// register map, field positions and vector constants for the interrupt controller
// Overview of operation
// RQ1: wake only if enabled before sleep, clockless
// RQ2: wake jumps to vector only with global enable
// RQ3: instruction after sleep runs before vector
// RQ4: edge select one rising, zero falling
// RQ5: valid edge sets flag, vectors when enabled
// RQ6: push only return pc on entry
// RQ7: load pc with vector, upper latch untouched
// RQ8: flags set regardless of any enable; the port change flag here still needs its pin change enable bit
// RQ9: global enable gates all interrupts
// RQ10: peripheral group enable gates peripheral interrupts
// RQ11: timer overflow flag bit 2, enable 5
// RQ12: external edge flag bit 1, enable 4
// RQ13: port change flag bit 0, enable 3
// RQ14: port change needs per-pin change enables
// RQ15: reset leaves timer count unchanged
// RQ16: converter done flag set every conversion
// RQ17: software alone clears converter done flag
// RQ18: converter wakes sleep only on rc clock
// RQ19: both enables clear resume in-line after wake
// RQ20: request is global and of gated pairs
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

`define ADDR_INTERRUPT_CONTROL 12'h000
`define ADDR_PERIPHERAL_FLAG 12'h004
`define ADDR_PERIPHERAL_ENABLE 12'h008
`define ADDR_PIN_CHANGE_ENABLE 12'h00C
`define ADDR_OPTION 12'h010
`define ADDR_CORE_STATUS 12'h014

`define RST_INTERRUPT_CONTROL 8'h00
`define RST_BYTE 8'h00

`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_GROUP_ENABLE 6
`define BIT_TIMER_OVERFLOW_ENABLE 5
`define BIT_EXT_EDGE_ENABLE 4
`define BIT_PORT_CHANGE_ENABLE 3
`define BIT_TIMER_OVERFLOW_FLAG 2
`define BIT_EXT_EDGE_FLAG 1
`define BIT_PORT_CHANGE_FLAG 0

`define BIT_CONVERTER_DONE 6
`define BIT_EDGE_SELECT 6
`define BIT_CONVERTER_RC_CLOCK 0

`define IRQ_VECTOR 13'h0004
`define PC_WIDTH 13

`endif

// ===== design/edge_detect.v
// external pin edge detector with selectable polarity
`timescale 1ns/1ps
module edge_detect (
  input wire pclk,
  input wire presetn,
  input wire pin,
  input wire rising_sel,
  output wire edge_seen
);
  reg pin_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end
  // rising when select is one, falling when zero
  assign edge_seen = rising_sel ? (pin & ~pin_q) : (~pin & pin_q); // see RQ4
endmodule

// ===== design/interrupt_control_and_wake.v
// interrupt control, vectoring and sleep wake logic with apb registers
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
module interrupt_control_and_wake (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timer_overflow,
  input wire ext_pin,
  input wire [7:0] port_pins,
  input wire converter_done,
  input wire sleep_req,
  input wire instr_retire,
  input wire [12:0] return_pc,
  output reg sleeping,
  output reg wake,
  output reg irq_req,
  output reg push_req,
  output reg [12:0] push_data,
  output reg pc_load,
  output reg [12:0] pc_value
);
  localparam ST_RUN = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_POST = 2'd2;
  localparam ST_VECTOR = 2'd3;

  reg [7:0] interrupt_control;
  reg [7:0] peripheral_flag_reg;
  reg [7:0] peripheral_enable_reg;
  reg [7:0] pin_change_enable_reg;
  reg [7:0] option_reg;
  reg [7:0] port_q;
  reg [7:0] sleep_enables;
  reg [7:0] sleep_periph_enables;
  reg [1:0] state;
  reg [1:0] next_state;
  wire edge_seen;
  wire [7:0] pin_changed;
  wire port_change_event;
  wire wr_strobe;
  wire rd_access;
  wire addr_hit;
  wire wr_ictl;
  wire wr_pflag;
  wire [7:0] next_ictl;
  wire [7:0] next_pflag;
  wire core_pending;
  wire periph_pending;
  wire pending;
  wire wake_src;
  wire take_irq;

  edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_pin),
    .rising_sel(option_reg[`BIT_EDGE_SELECT]),
    .edge_seen(edge_seen)
  );

  // per-pin change detect; unmonitored pins never raise the flag
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      assign pin_changed[gi] = (port_pins[gi] ^ port_q[gi]) &
        pin_change_enable_reg[gi]; // see RQ14
    end
  endgenerate
  assign port_change_event = |pin_changed; // see RQ13

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_q <= 8'h00;
    end else begin
      port_q <= port_pins;
    end
  end

  // apb decode: zero wait state, every access answered in its access phase
  assign wr_strobe = psel & penable & pwrite;
  assign rd_access = psel & ~pwrite;
  assign addr_hit = (paddr == `ADDR_INTERRUPT_CONTROL) | (paddr == `ADDR_PERIPHERAL_FLAG) |
    (paddr == `ADDR_PERIPHERAL_ENABLE) | (paddr == `ADDR_PIN_CHANGE_ENABLE) |
    (paddr == `ADDR_OPTION) | (paddr == `ADDR_CORE_STATUS);
  assign wr_ictl = wr_strobe & (paddr == `ADDR_INTERRUPT_CONTROL);
  assign wr_pflag = wr_strobe & (paddr == `ADDR_PERIPHERAL_FLAG);

  // hardware sets win over a software write in the same cycle
  assign next_ictl = {
    (wr_ictl ? pwdata[7:3] : interrupt_control[7:3]),
    (wr_ictl ? pwdata[2] : interrupt_control[2]) | timer_overflow, // see RQ11 RQ8
    (wr_ictl ? pwdata[1] : interrupt_control[1]) | edge_seen, // see RQ12 RQ5 RQ8
    (wr_ictl ? pwdata[0] : interrupt_control[0]) | port_change_event // see RQ13 RQ8
  };
  // converter done only ever set here; clearing is software's job
  assign next_pflag = {
    (wr_pflag ? pwdata[7] : peripheral_flag_reg[7]),
    (wr_pflag ? pwdata[6] : peripheral_flag_reg[6]) | converter_done, // see RQ16 RQ17
    (wr_pflag ? pwdata[5:0] : peripheral_flag_reg[5:0])
  };

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control <= `RST_INTERRUPT_CONTROL;
      peripheral_flag_reg <= `RST_BYTE;
      peripheral_enable_reg <= `RST_BYTE;
      pin_change_enable_reg <= `RST_BYTE;
      option_reg <= `RST_BYTE;
    end else begin
      interrupt_control <= next_ictl;
      peripheral_flag_reg <= next_pflag;
      if (wr_strobe && paddr == `ADDR_PERIPHERAL_ENABLE) begin
        peripheral_enable_reg <= pwdata[7:0];
      end
      if (wr_strobe && paddr == `ADDR_PIN_CHANGE_ENABLE) begin
        pin_change_enable_reg <= pwdata[7:0];
      end
      if (wr_strobe && paddr == `ADDR_OPTION) begin
        option_reg <= pwdata[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_hit;
      prdata <= 32'h0000_0000;
      if (rd_access && !penable) begin
        case (paddr)
          `ADDR_INTERRUPT_CONTROL: prdata <= {24'h00_0000, interrupt_control};
          `ADDR_PERIPHERAL_FLAG: prdata <= {24'h00_0000, peripheral_flag_reg};
          `ADDR_PERIPHERAL_ENABLE: prdata <= {24'h00_0000, peripheral_enable_reg};
          `ADDR_PIN_CHANGE_ENABLE: prdata <= {24'h00_0000, pin_change_enable_reg};
          `ADDR_OPTION: prdata <= {24'h00_0000, option_reg};
          `ADDR_CORE_STATUS: prdata <= {28'h000_0000, state, irq_req, sleeping};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // request: global and (core pairs or group-gated peripheral pairs)
  assign core_pending =
    (interrupt_control[`BIT_TIMER_OVERFLOW_FLAG] & interrupt_control[`BIT_TIMER_OVERFLOW_ENABLE]) |
    (interrupt_control[`BIT_EXT_EDGE_FLAG] & interrupt_control[`BIT_EXT_EDGE_ENABLE]) |
    (interrupt_control[`BIT_PORT_CHANGE_FLAG] & interrupt_control[`BIT_PORT_CHANGE_ENABLE]);
  assign periph_pending = interrupt_control[`BIT_PERIPHERAL_GROUP_ENABLE] &
    |(peripheral_flag_reg & peripheral_enable_reg); // see RQ10 RQ20
  assign pending = interrupt_control[`BIT_GLOBAL_IRQ_ENABLE] &
    (core_pending | periph_pending); // see RQ9 RQ20

  // wake uses enables latched at sleep entry; only clockless sources count:
  // the edge pin, the port change and the converter on its rc clock
  assign wake_src =
    (interrupt_control[`BIT_EXT_EDGE_FLAG] & sleep_enables[`BIT_EXT_EDGE_ENABLE]) |
    (interrupt_control[`BIT_PORT_CHANGE_FLAG] & sleep_enables[`BIT_PORT_CHANGE_ENABLE]) |
    (peripheral_flag_reg[`BIT_CONVERTER_DONE] & sleep_periph_enables[`BIT_CONVERTER_DONE] &
     option_reg[`BIT_CONVERTER_RC_CLOCK]); // see RQ1 RQ18

  assign take_irq = (state == ST_RUN) & pending & ~sleep_req;

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (take_irq) begin
          next_state = ST_VECTOR;
        end else if (sleep_req) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_src) begin
          next_state = ST_POST;
        end
      end
      ST_POST: begin
        // the instruction after sleep retires first, then vector if allowed
        if (instr_retire) begin
          next_state = pending ? ST_VECTOR : ST_RUN; // see RQ3 RQ2 RQ19
        end
      end
      ST_VECTOR: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // timer count lives outside; this reset touches only control state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
      sleep_enables <= 8'h00;
      sleep_periph_enables <= 8'h00;
      sleeping <= 1'b0;
      wake <= 1'b0;
      irq_req <= 1'b0;
      push_req <= 1'b0;
      push_data <= 13'h0000;
      pc_load <= 1'b0;
      pc_value <= 13'h0000;
    end else begin
      state <= next_state; // see RQ15
      if (state == ST_RUN && sleep_req) begin
        sleep_enables <= interrupt_control; // see RQ1
        sleep_periph_enables <= peripheral_enable_reg;
      end
      sleeping <= (next_state == ST_SLEEP);
      wake <= (state == ST_SLEEP) & wake_src;
      irq_req <= pending;
      // entry: push only the return pc, load vector, upper latch left alone
      push_req <= (next_state == ST_VECTOR) & (state != ST_VECTOR); // see RQ6
      push_data <= return_pc; // see RQ6
      pc_load <= (next_state == ST_VECTOR) & (state != ST_VECTOR); // see RQ7
      pc_value <= `IRQ_VECTOR; // see RQ7
    end
  end
endmodule

// ===== sim/irq_ctrl_chk.sv
// port assertions for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sleep_req,
  input wire instr_retire,
  input wire sleeping,
  input wire wake,
  input wire push_req,
  input wire pc_load,
  input wire [12:0] pc_value
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // open from a wake until the core retires the next instruction
  reg wait_ret;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wait_ret <= 1'b0;
    else if (wake)
      wait_ret <= 1'b1;
    else if (instr_retire)
      wait_ret <= 1'b0;
  end
  sequence s_setup; psel && !penable; endsequence
  property p_apb; s_setup |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("no ready after setup");
  property p_err; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("refused read not zero");
  property p_vec; pc_load |-> pc_value == 13'h0004; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_pulse; pc_load |=> !pc_load; endproperty
  a_pulse: assert property (p_pulse) else $error("pc load too long");
  property p_push; push_req == pc_load; endproperty
  a_push: assert property (p_push) else $error("push without load");
  property p_ret; wait_ret |-> !pc_load; endproperty
  a_ret: assert property (p_ret) else $error("vector before retire");
  property p_asleep; sleeping |-> !pc_load; endproperty
  a_asleep: assert property (p_asleep) else $error("vector in sleep");
  property p_sleep; $rose(sleeping) |-> $past(sleep_req); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep uncaused");
  property p_wake; wake |-> $past(sleeping) && !sleeping; endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
endmodule
bind interrupt_control_and_wake irq_ctrl_chk i_chk (.pclk, .presetn, .psel, .penable, .prdata,
  .pready, .pslverr, .sleep_req, .instr_retire, .sleeping, .wake, .push_req, .pc_load, .pc_value);

// ===== sim/core_model.sv
// core sequencer model: retires one instruction after a wake
`timescale 1ns/1ps
module core_model (
  input wire pclk,
  input wire presetn,
  input wire wake,
  input wire [2:0] lag,
  output reg instr_retire,
  output reg [12:0] return_pc
);
  reg [3:0] cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      instr_retire <= 1'b0;
      return_pc <= 13'h0123;
    end else begin
      instr_retire <= (cnt == 4'h1);
      if (wake)
        cnt <= {1'b0, lag} + 4'h2;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      if (cnt == 4'h1)
        return_pc <= return_pc + 13'h0001;
    end
  end
endmodule

// ===== sim/tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
module tb;
  reg pclk = 0;
  reg presetn = 0;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg ext_pin = 0;
  reg [7:0] port_pins = 0;
  reg [2:0] ev = 0;
  reg [2:0] lag = 0;
  reg [7:0] x, y, z;
  reg [31:0] r;
  reg e;
  wire [31:0] prdata;
  wire pready, pslverr, instr_retire, sleeping, wake, irq_req, push_req, pc_load;
  wire [12:0] return_pc, push_data, pc_value;
  integer bad_count = 0;
  integer comparisons = 0;
  integer seed = 32'h182a;
  integer i;
  interrupt_control_and_wake i_interrupt_control_and_wake (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_overflow(ev[0]),
    .ext_pin(ext_pin), .port_pins(port_pins), .converter_done(ev[1]), .sleep_req(ev[2]),
    .instr_retire(instr_retire), .return_pc(return_pc), .sleeping(sleeping), .wake(wake),
    .irq_req(irq_req), .push_req(push_req), .push_data(push_data), .pc_load(pc_load),
    .pc_value(pc_value));
  core_model i_core_model (.pclk(pclk), .presetn(presetn), .wake(wake), .lag(lag),
    .instr_retire(instr_retire), .return_pc(return_pc));
  initial forever #12.5 pclk = ~pclk;
  function [7:0] pc_flag(input [7:0] was, input [7:0] now, input [7:0] en);
    pc_flag = {7'h00, |((was ^ now) & en)};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input [11:0] a, input w, input [7:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] exp);
    begin
      apb(a, 1'b0, 8'h00);
      chk(r, {24'h00_0000, exp});
    end
  endtask
  task pulse(input [2:0] m);
    begin
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 3'h0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task pin(input v);
    begin
      @(posedge pclk);
      ext_pin <= v;
      repeat (3) @(posedge pclk);
    end
  endtask
  task await(input exp);
    integer n;
    reg got;
    begin
      got = 1'b0;
      for (n = 0; n < 24 && !got; n = n + 1) begin
        @(posedge pclk);
        if (pc_load === 1'b1) begin
          got = 1'b1;
          chk(pc_value, `IRQ_VECTOR);
          chk(push_data, return_pc);
        end
      end
      chk(got, exp);
      chk(irq_req, exp);
    end
  endtask
  // clearing first lets any vector already in flight drain before the check
  task vec(input [7:0] ctl, input exp);
    begin
      apb(`ADDR_INTERRUPT_CONTROL, 1'b1, 8'h00);
      repeat (4) @(posedge pclk);
      apb(`ADDR_INTERRUPT_CONTROL, 1'b1, ctl);
      await(exp);
    end
  endtask
  task sl(input [7:0] ctl, input exp);
    begin
      apb(`ADDR_INTERRUPT_CONTROL, 1'b1, ctl);
      pulse(3'b100);
      pulse(3'b001);
      chk(sleeping, 1'b1);
      pin(1'b0);
      pin(1'b1);
      await(exp);
      chk(sleeping, 1'b0);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count = bad_count + 1;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
      rd({i[9:0], 2'b00}, 8'h00);
    apb(12'h020, 1'b0, 8'h00);
    chk({r[30:0], e}, 32'h0000_0001);
    for (i = 0; i < 6; i = i + 1) begin
      x = (i == 0) ? 8'h00 : $random(seed);
      y = $random(seed);
      lag <= y[2:0];
      apb(`ADDR_PIN_CHANGE_ENABLE, 1'b1, x);
      rd(`ADDR_PIN_CHANGE_ENABLE, x);
      apb(`ADDR_INTERRUPT_CONTROL, 1'b1, 8'h00);
      z = pc_flag(port_pins, y, x);
      port_pins <= y;
      repeat (3) @(posedge pclk);
      rd(`ADDR_INTERRUPT_CONTROL, z);
    end
    $display("registers done");
    for (i = 0; i < 2; i = i + 1) begin
      apb(`ADDR_OPTION, 1'b1, {1'b0, i[0], 6'h00});
      pin(i[0]);
      apb(`ADDR_INTERRUPT_CONTROL, 1'b1, 8'h00);
      pin(!i[0]);
      rd(`ADDR_INTERRUPT_CONTROL, 8'h00);
      pin(i[0]);
      rd(`ADDR_INTERRUPT_CONTROL, 8'h02);
    end
    pulse(3'b001);
    repeat (20) @(posedge pclk);
    rd(`ADDR_INTERRUPT_CONTROL, 8'h06);
    pulse(3'b010);
    rd(`ADDR_PERIPHERAL_FLAG, 8'h40);
    $display("flags done");
    vec(8'h24, 1'b0);
    vec(8'hA4, 1'b1);
    apb(`ADDR_PERIPHERAL_ENABLE, 1'b1, 8'h40);
    vec(8'h80, 1'b0);
    vec(8'hC0, 1'b1);
    rd(`ADDR_PERIPHERAL_FLAG, 8'h40);
    apb(`ADDR_PERIPHERAL_ENABLE, 1'b1, 8'h00);
    $display("vectors done");
    sl(8'h30, 1'b0);
    sl(8'hB0, 1'b1);
    $display("sleep done");
    wrap_up;
  end
endmodule
